// ### logic/qrd_map.svh
// constant map shared by both ends of the quad read link
`ifndef QRD_MAP_SVH
`define QRD_MAP_SVH

`define QRD_CMD_FRQ_EXT 8'hEB
`define QRD_CMD_FRQ_4B  8'hEC
`define QRD_CONT_CODE   4'hA
`define QRD_EXIT_CODE   4'h0
`define QRD_CMD_CYC     4'h8
`define QRD_ADDR_CYC    4'h8
`define QRD_MODE_CYC    4'h2
`define QRD_DUMMY_DEF   4'h6
`define QRD_SCK_HALF    2'h3
`define QRD_FILL_FULL   2'h2
`define QRD_IO_IDLE     4'hF
`define QRD_IO_ALL      4'hF
`define QRD_IO_LINE0    4'h1
`define QRD_BYTE_IDLE   8'hFF

`endif

// ### logic/qrd_pkg.sv
// types and shared helpers of the quad read link
package qrd_pkg;
`include "qrd_map.svh"

	typedef enum logic [2:0] {
		QRD_P_START  = 3'b000,
		QRD_P_CMD    = 3'b001,
		QRD_P_ADDR   = 3'b010,
		QRD_P_WAIT   = 3'b011,
		QRD_P_DATA   = 3'b100,
		QRD_P_IGNORE = 3'b101
	} qrd_phase_t;

	typedef enum logic [1:0] {
		QRD_H_IDLE  = 2'b00,
		QRD_H_SHIFT = 2'b01,
		QRD_H_GAP   = 2'b10
	} qrd_hstate_t;

	// wait cycles after the address, continuation cycles included
	function automatic logic [3:0] qrd_dummy_eff(input logic [3:0] n);
		return (n < `QRD_MODE_CYC) ? `QRD_MODE_CYC : n;
	endfunction

endpackage

// ### logic/qrd_if.sv
// pin bundle between host controller and flash end
interface qrd_if;
	logic       cs_n;
	logic       sck;
	logic [3:0] host_o;
	logic [3:0] host_oe;
	logic [3:0] dev_o;
	logic [3:0] dev_oe;
	logic [3:0] io;
	logic       clash;

	// undriven lines float high as with a pull-up
	assign io = (dev_oe & dev_o) | (~dev_oe & host_oe & host_o)
		| (~dev_oe & ~host_oe);
	assign clash = |(dev_oe & host_oe);

	modport host(output cs_n, sck, host_o, host_oe, input io);
	modport dev(input cs_n, sck, io, output dev_o, dev_oe);
endinterface

// ### logic/qrd_flash.sv
// flash end: quad I/O fast read with 4-byte address and continuous mode
// How it works
// - EBh with four-byte select, or ECh, opens read
// - continuation nibble A keeps continuous read, no instruction
// - other continuation nibble exits, next frame needs instruction
// - dummy count programmable, default six cycles
// - host sets dummies so drivers never overlap
// - equal counts: host floats lower continuation nibble
// - continuation byte two cycles, upper nibble decoded only
// - dummy count includes the two continuation cycles
// - instruction shifts in on IO0 over eight clocks
`include "qrd_map.svh"
module qrd_flash
	import qrd_pkg::*;
(
	// flash pins
	qrd_if.dev         PINS,
	// reset, sampled on the serial clock and, for the mode, at chip select rise
	input  wire logic        RST_N,
	// configuration
	input  wire logic        FOUR_BYTE_ADDRESS_SELECT,
	input  wire logic [3:0]  DUMMY_CYCLES,
	// array read request
	output      logic [31:0] RD_ADDR,
	output      logic        RD_START,
	// array data stream
	input  wire logic [7:0]  DIN,
	input  wire logic        DIN_VALID,
	output      logic        DIN_READY,
	// status
	output      logic        CONTINUOUS_READ_MODE,
	output      logic        UNDERRUN
);

	typedef struct packed {
		qrd_phase_t       phase;
		logic [3:0]       cnt;
		logic [7:0]       cmd;
		logic [31:0]      addr;
		logic             rd_start;
		logic             mode_seen;
		logic             mode_ok;
		logic             nib_lo;
		logic [7:0]       cur;
		logic [3:0]       io_o;
		logic             io_oe;
		logic [1:0][7:0]  fifo;
		logic [1:0]       fill;
		logic             underrun;
	} qrd_dev_t;

	localparam qrd_dev_t QRD_DEV_RST = '{
		phase:     QRD_P_START,
		cnt:       4'h0,
		cmd:       8'h00,
		addr:      32'h0000_0000,
		rd_start:  1'b0,
		mode_seen: 1'b0,
		mode_ok:   1'b0,
		nib_lo:    1'b0,
		cur:       8'h00,
		io_o:      4'h0,
		io_oe:     1'b0,
		fifo:      16'h0000,
		fill:      2'h0,
		underrun:  1'b0
	};

	qrd_dev_t   q;
	qrd_dev_t   d;
	qrd_phase_t ph;
	logic       cont_q;
	logic       take;
	logic       pop;
	logic       push;
	logic [1:0] n;
	logic [3:0] dmy;
	logic [7:0] cmd_in;

	function automatic logic cmd_ok(input logic [7:0] c, input logic ext);
		return (c == `QRD_CMD_FRQ_4B) || (ext && c == `QRD_CMD_FRQ_EXT);
	endfunction

	assign DIN_READY = !PINS.cs_n && (q.fill != `QRD_FILL_FULL);
	assign push = DIN_VALID && DIN_READY;
	assign dmy = qrd_dummy_eff(DUMMY_CYCLES);
	assign cmd_in = {q.cmd[6:0], PINS.io[0]};

	always_comb begin
		d = q;
		take = 1'b0;
		pop = 1'b0;
		d.rd_start = 1'b0;
		// a frame in continuous mode opens straight at the address
		ph = q.phase;
		if (q.phase == QRD_P_START) begin
			ph = cont_q ? QRD_P_ADDR : QRD_P_CMD;
		end
		case (ph)
			QRD_P_CMD: begin
				d.cmd = cmd_in;
				d.cnt = q.cnt + 4'h1;
				d.phase = QRD_P_CMD;
				if (q.cnt == `QRD_CMD_CYC - 4'h1) begin
					d.cnt = 4'h0;
					if (cmd_ok(cmd_in, FOUR_BYTE_ADDRESS_SELECT)) begin
						d.phase = QRD_P_ADDR;
					end else begin
						d.phase = QRD_P_IGNORE;
					end
				end
			end
			QRD_P_ADDR: begin
				d.addr = {q.addr[27:0], PINS.io};
				d.cnt = q.cnt + 4'h1;
				d.phase = QRD_P_ADDR;
				if (q.cnt == `QRD_ADDR_CYC - 4'h1) begin
					d.cnt = 4'h0;
					d.phase = QRD_P_WAIT;
					d.rd_start = 1'b1;
				end
			end
			QRD_P_WAIT: begin
				d.cnt = q.cnt + 4'h1;
				// the lower continuation nibble is never looked at
				if (q.cnt == 4'h0) begin
					d.mode_seen = 1'b1;
					d.mode_ok = (PINS.io == `QRD_CONT_CODE);
				end
				// first nibble goes out so the host sees it next edge
				if (q.cnt == dmy - 4'h1) begin
					d.phase = QRD_P_DATA;
					take = 1'b1;
				end
			end
			QRD_P_DATA: begin
				if (q.nib_lo) begin
					d.io_o = q.cur[3:0];
					d.nib_lo = 1'b0;
				end else begin
					take = 1'b1;
				end
			end
			QRD_P_IGNORE: begin
				d.io_oe = 1'b0;
			end
			default: begin
				d.phase = QRD_P_IGNORE;
				d.io_oe = 1'b0;
			end
		endcase

		// an empty buffer sends idle ones rather than stall the link
		if (take) begin
			d.io_oe = 1'b1;
			d.nib_lo = 1'b1;
			if (q.fill != 2'h0) begin
				pop = 1'b1;
				d.cur = q.fifo[0];
				d.io_o = q.fifo[0][7:4];
			end else begin
				d.cur = `QRD_BYTE_IDLE;
				d.io_o = `QRD_IO_IDLE;
				d.underrun = 1'b1;
			end
		end

		n = q.fill;
		if (pop) begin
			d.fifo[0] = q.fifo[1];
			n = n - 2'h1;
		end
		if (push) begin
			d.fifo[n[0]] = DIN;
			n = n + 2'h1;
		end
		d.fill = n;

		if (!RST_N) begin
			d = QRD_DEV_RST;
		end
	end

	// chip select high ends the frame and clears all frame state
	always_ff @(posedge PINS.sck or posedge PINS.cs_n) begin
		if (PINS.cs_n) begin
			q <= QRD_DEV_RST;
		end else begin
			q <= d;
		end
	end

	// the mode decision is taken over at frame end; a frame cut
	// short before the continuation byte keeps the old mode
	always_ff @(posedge PINS.cs_n) begin
		if (!RST_N) begin
			cont_q <= 1'b0;
		end else if (q.mode_seen) begin
			cont_q <= q.mode_ok;
		end
	end

	assign PINS.dev_o = q.io_o;
	assign PINS.dev_oe = {4{q.io_oe}};
	assign RD_ADDR = q.addr;
	assign RD_START = q.rd_start;
	assign CONTINUOUS_READ_MODE = cont_q;
	assign UNDERRUN = q.underrun;

endmodule // qrd_flash

// ### logic/qrd_host.sv
// host end: issues quad I/O fast reads and collects the bytes
`include "qrd_map.svh"
module qrd_host
	import qrd_pkg::*;
(
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RST_N,
	// flash pins
	qrd_if.host        PINS,
	// read request
	input  wire logic        START,
	input  wire logic [31:0] ADDR,
	input  wire logic [7:0]  NBYTES,
	input  wire logic        USE_4B_CODE,
	input  wire logic        KEEP_CONT,
	input  wire logic [3:0]  DUMMY_CYCLES,
	output      logic        BUSY,
	output      logic        CONT_ACTIVE,
	// read data stream
	output      logic [7:0]  DOUT,
	output      logic        DOUT_VALID,
	input  wire logic        DOUT_READY
);

	typedef struct packed {
		qrd_hstate_t      st;
		logic [1:0]       div;
		logic             sck;
		logic             cs_n;
		logic [9:0]       cyc;
		logic [9:0]       total;
		logic [9:0]       dstart;
		logic [7:0]       code;
		logic [31:0]      addr;
		logic             keep;
		logic             skip;
		logic             cont;
		logic [3:0]       io_o;
		logic [3:0]       io_oe;
		logic [3:0]       s1;
		logic [3:0]       s2;
		logic [3:0]       hi;
		logic [1:0][7:0]  fifo;
		logic [1:0]       fill;
	} qrd_hst_t;

	localparam qrd_hst_t QRD_HST_RST = '{
		st: QRD_H_IDLE, div: 2'h0, sck: 1'b0, cs_n: 1'b1,
		cyc: 10'h000, total: 10'h000, dstart: 10'h000, code: 8'h00,
		addr: 32'h0000_0000, keep: 1'b0, skip: 1'b0, cont: 1'b0,
		io_o: 4'h0, io_oe: 4'h0, s1: `QRD_IO_IDLE, s2: `QRD_IO_IDLE,
		hi: 4'h0, fifo: 16'h0000, fill: 2'h0
	};

	qrd_hst_t   q;
	qrd_hst_t   d;
	logic       pop;
	logic       dat;
	logic [1:0] n;
	logic [9:0] cc;

	// pin values for link cycle k: {output enables, outputs}
	function automatic logic [7:0] drive_at(input logic [9:0] k,
			input qrd_hst_t s);
		logic [9:0] c;
		logic [9:0] i;
		c = s.skip ? 10'h000 : 10'(`QRD_CMD_CYC);
		i = k - c;
		if (k < c) begin
			return {`QRD_IO_LINE0, 3'b000, s.code[3'h7 - k[2:0]]};
		end else if (i < 10'(`QRD_ADDR_CYC)) begin
			return {`QRD_IO_ALL, s.addr[{3'h7 - i[2:0], 2'b00} +: 4]};
		end else if (i == 10'(`QRD_ADDR_CYC)) begin
			return {`QRD_IO_ALL, s.keep ? `QRD_CONT_CODE : `QRD_EXIT_CODE};
		end
		// lines float from the lower continuation nibble onward
		return 8'h00;
	endfunction

	assign pop = DOUT_READY && (q.fill != 2'h0);
	assign dat = q.cyc >= q.dstart;

	always_comb begin
		d = q;
		d.s1 = PINS.io;
		d.s2 = q.s1;
		cc = 10'h000;
		case (q.st)
			QRD_H_IDLE: begin
				if (START) begin
					d.code = USE_4B_CODE ? `QRD_CMD_FRQ_4B
						: `QRD_CMD_FRQ_EXT;
					d.addr = ADDR;
					d.keep = KEEP_CONT;
					d.skip = q.cont;
					cc = q.cont ? 10'h000 : 10'(`QRD_CMD_CYC);
					d.dstart = cc + 10'(`QRD_ADDR_CYC)
						+ 10'(qrd_dummy_eff(DUMMY_CYCLES));
					d.total = d.dstart + {1'b0, NBYTES, 1'b0};
					d.cyc = 10'h000;
					d.div = 2'h0;
					d.sck = 1'b0;
					d.cs_n = 1'b0;
					{d.io_oe, d.io_o} = drive_at(10'h000, d);
					d.st = QRD_H_SHIFT;
				end
			end
			QRD_H_SHIFT: begin
				d.div = q.div + 2'h1;
				if (q.div == `QRD_SCK_HALF - 2'h1) begin
					d.div = 2'h0;
					if (!q.sck) begin
						// a full buffer holds the clock low
						if (dat && q.cyc[0] != q.dstart[0]
								&& q.fill == `QRD_FILL_FULL) begin
							d.div = q.div;
						end else begin
							d.sck = 1'b1;
							d.hi = q.s2;
						end
					end else begin
						d.sck = 1'b0;
						d.cyc = q.cyc + 10'h001;
						if (q.cyc + 10'h001 == q.total) begin
							d.st = QRD_H_GAP;
							d.cs_n = 1'b1;
							d.io_oe = 4'h0;
							d.cont = q.keep;
						end else begin
							{d.io_oe, d.io_o} = drive_at(d.cyc, q);
						end
					end
				end
			end
			QRD_H_GAP: begin
				d.div = q.div + 2'h1;
				if (q.div == `QRD_SCK_HALF - 2'h1) begin
					d.st = QRD_H_IDLE;
				end
			end
			default: begin
				d.st = QRD_H_IDLE;
			end
		endcase

		n = q.fill;
		if (pop) begin
			d.fifo[0] = q.fifo[1];
			n = n - 2'h1;
		end
		// second nibble of a byte completes it
		if (q.st == QRD_H_SHIFT && d.sck && !q.sck && dat
				&& q.cyc[0] != q.dstart[0]) begin
			d.fifo[n[0]] = {q.hi, q.s2};
			n = n + 2'h1;
		end
		d.fill = n;

		if (!RST_N) begin
			d = QRD_HST_RST;
		end
	end

	always_ff @(posedge CLK) begin
		q <= d;
	end

	assign PINS.cs_n = q.cs_n;
	assign PINS.sck = q.sck;
	assign PINS.host_o = q.io_o;
	assign PINS.host_oe = q.io_oe;
	assign BUSY = q.st != QRD_H_IDLE;
	assign CONT_ACTIVE = q.cont;
	assign DOUT = q.fifo[0];
	assign DOUT_VALID = q.fill != 2'h0;

endmodule // qrd_host

// ### testbench/qrd_link_checker.sv
// pin-level checks on the link between the host and flash ends
module qrd_link_checker (
	// host clock and reset
	input wire logic       CLK,
	input wire logic       RST_N,
	// link pins
	input wire logic       cs_n,
	input wire logic       sck,
	input wire logic [3:0] host_o,
	input wire logic [3:0] host_oe,
	input wire logic [3:0] dev_o,
	input wire logic [3:0] dev_oe,
	input wire logic       clash
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       sck_q;
	logic       cont_q;
	logic [3:0] ho_q;
	logic [3:0] hoe_q;
	logic [3:0] icnt_q;
	wire        leave = !cs_n && hoe_q == 4'hF && host_oe != 4'hF;

	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);

	// the host's own continuation nibble decides whether it may skip the
	// instruction next time, so it is remembered when the host lets go
	always_ff @(posedge CLK) begin
		sck_q <= sck;
		ho_q <= host_o;
		hoe_q <= host_oe;
		if (!RST_N || cs_n)
			icnt_q <= 4'h0;
		else if (sck && !sck_q && host_oe == 4'h1)
			icnt_q <= icnt_q + 4'h1;
		if (!RST_N)
			cont_q <= 1'b0;
		else if (leave)
			cont_q <= ho_q == 4'hA;
	end

	property p_no_clash;
		!clash;
	endproperty
	a_no_clash: assert property (p_no_clash)
		else $error("host and flash drive io together");

	property p_float_all;
		leave |-> host_oe == 4'h0;
	endproperty
	a_float_all: assert property (p_float_all)
		else $error("host kept part of io driven");

	property p_mode_gap;
		leave |-> dev_oe == 4'h0 [*3];
	endproperty
	a_mode_gap: assert property (p_mode_gap)
		else $error("flash drove io in the second continuation cycle");

	property p_instr_len;
		(!cs_n && hoe_q == 4'h1 && host_oe == 4'hF) |-> icnt_q == 4'h8;
	endproperty
	a_instr_len: assert property (p_instr_len)
		else $error("instruction not eight clocks on io0");

	property p_skip_instr;
		$fell(cs_n) |-> host_oe == (cont_q ? 4'hF : 4'h1);
	endproperty
	a_skip_instr: assert property (p_skip_instr)
		else $error("frame start does not follow continuation nibble");

	property p_dev_uniform;
		dev_oe == 4'h0 || dev_oe == 4'hF;
	endproperty
	a_dev_uniform: assert property (p_dev_uniform)
		else $error("flash drives only some io lines");

	property p_host_on_fall;
		(!cs_n && !$past(cs_n) && (host_o != ho_q || host_oe != hoe_q))
			|-> !sck;
	endproperty
	a_host_on_fall: assert property (p_host_on_fall)
		else $error("host io changed while sck high");

	property p_dev_on_rise;
		(!cs_n && !$past(cs_n) && $changed(dev_o)) |-> sck;
	endproperty
	a_dev_on_rise: assert property (p_dev_on_rise)
		else $error("flash io changed while sck low");

	property p_dev_quiet;
		(cs_n && $past(cs_n)) |-> dev_oe == 4'h0;
	endproperty
	a_dev_quiet: assert property (p_dev_quiet)
		else $error("flash drives io while deselected");
endmodule // qrd_link_checker

// ### testbench/test_quad_io_fast_read_continuous.sv
// self-checking bench: host and flash ends joined over the quad link
module test_quad_io_fast_read_continuous;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        frst_n = 1'b0;
	logic        start = 1'b0;
	logic        use4b = 1'b0;
	logic        keep = 1'b0;
	logic        sel = 1'b0;
	logic        dout_ready = 1'b0;
	logic        run_q = 1'b0;
	logic        under_seen = 1'b0;
	logic        starve = 1'b0;
	logic [7:0]  exp_q[$];
	logic        busy, cont_active, dout_valid, rd_start, din_ready;
	logic        din_valid, cont_mode, underrun;
	logic [3:0]  dummy = 4'h6;
	logic [7:0]  nbytes = 8'h00;
	logic [7:0]  dout, din;
	logic [31:0] addr = 32'h0;
	logic [31:0] ptr_q = 32'h0;
	logic [31:0] rd_addr, got_addr, cur;
	int          fails = 0;
	int          n_compared = 0;
	int          n_starts = 0;
	int          cont = 0;

	initial forever #5 clk = ~clk;

	qrd_if qrd_if_inst();
	qrd_host qrd_host_inst(
		.CLK(clk), .RST_N(rst_n), .PINS(qrd_if_inst.host), .START(start),
		.ADDR(addr), .NBYTES(nbytes), .USE_4B_CODE(use4b), .KEEP_CONT(keep),
		.DUMMY_CYCLES(dummy), .BUSY(busy), .CONT_ACTIVE(cont_active),
		.DOUT(dout), .DOUT_VALID(dout_valid), .DOUT_READY(dout_ready));
	qrd_flash qrd_flash_inst(
		.PINS(qrd_if_inst.dev), .RST_N(frst_n), .DUMMY_CYCLES(dummy),
		.FOUR_BYTE_ADDRESS_SELECT(sel), .RD_ADDR(rd_addr),
		.RD_START(rd_start), .DIN(din), .DIN_VALID(din_valid),
		.DIN_READY(din_ready), .CONTINUOUS_READ_MODE(cont_mode),
		.UNDERRUN(underrun));
	qrd_link_checker qrd_link_checker_inst(
		.CLK(clk), .RST_N(rst_n), .cs_n(qrd_if_inst.cs_n),
		.sck(qrd_if_inst.sck), .host_o(qrd_if_inst.host_o),
		.host_oe(qrd_if_inst.host_oe), .dev_o(qrd_if_inst.dev_o),
		.dev_oe(qrd_if_inst.dev_oe), .clash(qrd_if_inst.clash));

	function automatic logic [7:0] mem(input logic [31:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3C;
	endfunction

	// the first byte is offered in the start cycle itself, so even the
	// shortest wait of two cycles cannot run dry
	// starve withholds the stream so the flash must send idle bytes
	assign din_valid = !starve && (rd_start | run_q);
	assign cur = rd_start ? rd_addr : ptr_q;
	assign din = mem(cur);
	always @(posedge qrd_if_inst.sck or posedge qrd_if_inst.cs_n) begin
		if (qrd_if_inst.cs_n) begin
			run_q <= 1'b0;
		end else begin
			run_q <= din_valid;
			ptr_q <= cur + {31'h0, din_valid & din_ready};
		end
	end
	always @(negedge qrd_if_inst.sck) begin
		if (rd_start === 1'b1) begin
			n_starts++;
			got_addr = rd_addr;
		end
		if (underrun === 1'b1)
			under_seen = 1'b1;
	end

	task automatic chk(input string what, input logic [31:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// st holds the reader off long enough to fill the host buffer
	task automatic run(input logic c4, s, k, input logic [3:0] d,
		input logic [7:0] n, input int st, input logic live);
		logic [31:0] a;
		logic        acc;
		logic [7:0]  e;
		int          got, t, s0;
		a = $urandom;
		acc = live && (cont != 0 || c4 || s);
		s0 = n_starts;
		under_seen = 1'b0;
		got = 0;
		// refused frames read the pulled-up lines, starved ones idle bytes
		exp_q.delete();
		for (int j = 0; j < n; j++)
			exp_q.push_back((acc && !starve) ? mem(a + j) : 8'hFF);
		@(posedge clk);
		start <= 1'b1;
		addr <= a;
		nbytes <= n;
		use4b <= c4;
		keep <= k;
		sel <= s;
		dummy <= d;
		@(posedge clk);
		start <= 1'b0;
		@(negedge clk);
		for (t = 0; t < 4000 && (got < n || busy !== 1'b0); t++) begin
			@(posedge clk);
			dout_ready <= (t >= st) && ($urandom % 2 == 1);
			@(negedge clk);
			if (dout_valid === 1'b1 && dout_ready === 1'b1) begin
				e = exp_q.pop_front();
				chk("byte", {24'h0, e}, {24'h0, dout});
				got++;
			end
		end
		if (t >= 4000) begin
			$display("[ERR] bytes expected %0d seen %0d", n, got);
			fails++;
			results();
		end
		if (acc)
			cont = k;
		chk("starts", {31'h0, acc}, n_starts - s0);
		if (acc)
			chk("address", a, got_addr);
		chk("flash mode", cont, {31'h0, cont_mode});
		chk("host mode", cont, {31'h0, cont_active});
		chk("underrun", {31'h0, acc & starve}, {31'h0, under_seen});
	endtask

	initial begin
		void'($urandom(71));
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		run(1'b1, 1'b0, 1'b0, 4'h6, 8'h01, 0, 1'b0); // flash reset frame
		@(posedge clk);
		frst_n <= 1'b1;
		run(1'b1, 1'b0, 1'b1, 4'h6, 8'h04, 0, 1'b1);
		run(1'b0, 1'b0, 1'b1, 4'h4, 8'h06, 200, 1'b1);
		run(1'b0, 1'b0, 1'b0, 4'h2, 8'h03, 0, 1'b1);
		run(1'b0, 1'b1, 1'b0, 4'h0, 8'h02, 0, 1'b1);
		run(1'b0, 1'b0, 1'b0, 4'h6, 8'h02, 0, 1'b1); // refused code
		run(1'b1, 1'b1, 1'b1, 4'hF, 8'h03, 0, 1'b1);
		run(1'b1, 1'b0, 1'b0, 4'h3, 8'h00, 0, 1'b1);
		starve = 1'b1;
		run(1'b1, 1'b0, 1'b0, 4'h6, 8'h02, 0, 1'b1); // underrun
		results();
	end
endmodule // test_quad_io_fast_read_continuous
